// *** rtl/mtc_pkg.sv ***
// mtc_pkg: register map, field codes and reset values of the
// five-channel multimode timer.
// assumes a 32-bit classic wishbone slave with byte addresses.
package mtc_pkg;
   // ********************************************************
   // register offsets (byte addresses)
   // ********************************************************
   localparam logic [7:0] START_OFS = 8'h00; // count_start_reg
   localparam logic [7:0] POL_OFS = 8'h04; // output_polarity_reg
   localparam logic [7:0] STAT_OFS = 8'h08; // irq request flags
   localparam logic [7:0] MASK_OFS = 8'h0C;
   localparam logic [7:0] CUT_OFS = 8'h10; // cutoff_control_reg
   localparam logic [7:0] UD_OFS = 8'h14; // up_down_select_reg
   localparam logic [7:0] TRG_OFS = 8'h18; // trigger_select_reg
   localparam logic [7:0] CH_BASE = 8'h20; // chan_mode_reg of ch 0
   localparam int CH_STRIDE_SH = 3; // 8 bytes per channel
   localparam int CH_CNT_BIT = 2; // +4: chan_counter_reg
   // ********************************************************
   // field codes
   // ********************************************************
   localparam logic [1:0] MODE_TMR = 2'h0;
   localparam logic [1:0] MODE_EVT = 2'h1;
   localparam logic [1:0] MODE_OS = 2'h2;
   localparam logic [1:0] MODE_PWM = 2'h3;
   localparam logic [1:0] SRC_DIV1 = 2'h0;
   localparam logic [1:0] SRC_DIV8 = 2'h1;
   localparam logic [1:0] SRC_DIV32 = 2'h2;
   localparam logic [1:0] SRC_PIN = 2'h3;
   localparam int MODE_LSB = 0;
   localparam int SRC_LSB = 2;
   // ********************************************************
   // values and counts
   // ********************************************************
   localparam logic [15:0] CNT_RST = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] RD_UDF = 16'hFFFF; // read during reload
   localparam logic [15:0] RD_OVF = 16'h0000;
   localparam logic [4:0] CUT_CH_MASK = 5'h16; // channels 1, 2, 4
   localparam logic [4:0] PRE_DIV8 = 5'h07;
   localparam logic [4:0] PRE_DIV32 = 5'h1F;
   localparam logic [5:0] SYNC_RST = 6'h20; // shutdown pin idles high
   localparam int SD_BIT = 5;
endpackage : mtc_pkg

// *** rtl/mtc_timer.sv ***
// mtc_timer: five 16-bit timer channels (interval, event counter,
// one-shot, pwm) behind a classic wishbone register slave.
// assumes one clock, synchronous reset, and pins from outside the
// clock domain; software keeps mode changes to stopped channels.
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module mtc_timer #(
   parameter int NCH = 5
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic [4:0] chan_trigger_input_pin_i,
   input wire logic shutdown_input_pin_n_i,
   output logic [4:0] chan_output_pin_o,
   output logic [4:0] chan_output_oe_o,
   output logic irq_o
);
   // ********************************************************
   // parameter check
   // ********************************************************
   // the cutoff group and the 5-bit shared registers fix the count
   if (NCH != 5) begin : g_bad_nch
      $error("mtc_timer: NCH must be 5");
   end

   // byte-lane merge of a write into a 32-bit view of a register
   function automatic logic [31:0] mrg(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (old & ~m) | (d & m);
   endfunction : mrg

   // ********************************************************
   // declarations
   // ********************************************************
   logic ack_reg;
   logic [31:0] dat_reg;
   logic [31:0] rd_next;
   logic req, wr, rd;
   logic [7:0] ch_off;
   logic ch_hit;
   logic [2:0] ch_idx;
   logic [4:0] start_reg, start_q, pol_reg, mask_reg, stat_reg;
   logic [4:0] ud_reg, trg_reg;
   logic cut_reg;
   logic [1:0] mode_reg [NCH];
   logic [1:0] src_reg [NCH];
   logic [15:0] cnt_reg [NCH];
   logic [15:0] rel_reg [NCH];
   logic [4:0] out_reg, act_reg, rtg_reg, pend_reg;
   logic [4:0] rld_reg, kind_reg, uf_ev_reg;
   logic [4:0] stop_ev, mode_ev, cnt_wr, tick, trig, pin_rise;
   logic [5:0] s1_reg, s2_reg, s3_reg, flt_reg, flt_q;
   logic [4:0] pre_reg;

   // ********************************************************
   // wishbone slave
   // ********************************************************
   assign req = cyc_i & stb_i & ~ack_reg;
   assign wr = req & we_i;
   assign rd = req & ~we_i;
   assign ch_off = adr_i - mtc_pkg::CH_BASE;
   assign ch_hit = (adr_i >= mtc_pkg::CH_BASE) &&
      (ch_off[7:mtc_pkg::CH_STRIDE_SH] < 5'(NCH));
   assign ch_idx = ch_off[5:3];

   // one-cycle answer; ack falls in the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0000_0000;
      end else begin
         ack_reg <= req;
         if (rd) begin
            dat_reg <= rd_next;
         end
      end
   end
   assign ack_o = ack_reg;
   assign dat_o = dat_reg;

   // read mux; unmapped offsets read as zero
   always_comb begin
      rd_next = 32'h0000_0000;
      if (ch_hit) begin
         if (!adr_i[mtc_pkg::CH_CNT_BIT]) begin
            rd_next[3:0] = {src_reg[ch_idx], mode_reg[ch_idx]};
         end else if (rld_reg[ch_idx]) begin
            // counter reloaded at the last edge
            rd_next[15:0] = kind_reg[ch_idx] ? mtc_pkg::RD_OVF
               : mtc_pkg::RD_UDF;
         end else begin
            rd_next[15:0] = cnt_reg[ch_idx];
         end
      end else begin
         case (adr_i)
            mtc_pkg::START_OFS: rd_next[4:0] = start_reg;
            mtc_pkg::POL_OFS: rd_next[4:0] = pol_reg;
            mtc_pkg::STAT_OFS: rd_next[4:0] = stat_reg;
            mtc_pkg::MASK_OFS: rd_next[4:0] = mask_reg;
            mtc_pkg::CUT_OFS: rd_next[0] = cut_reg;
            mtc_pkg::UD_OFS: rd_next[4:0] = ud_reg;
            mtc_pkg::TRG_OFS: rd_next[4:0] = trg_reg;
            default: rd_next = 32'h0000_0000;
         endcase
      end
   end

   // ********************************************************
   // control registers
   // ********************************************************
   // setup is not locked while running; keeping it still is up to
   // software, so a running write simply takes effect
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_reg <= 5'h00;
         pol_reg <= 5'h00;
         mask_reg <= 5'h00;
         cut_reg <= 1'b0;
         ud_reg <= 5'h00;
         trg_reg <= 5'h00;
         for (int i = 0; i < NCH; i++) begin
            mode_reg[i] <= mtc_pkg::MODE_TMR;
            src_reg[i] <= mtc_pkg::SRC_DIV1;
         end
      end else if (wr) begin
         if (ch_hit && !adr_i[mtc_pkg::CH_CNT_BIT]) begin
            mode_reg[ch_idx] <= 2'(mrg(32'(mode_reg[ch_idx]),
               dat_i, sel_i));
            src_reg[ch_idx] <= 2'(mrg(32'(src_reg[ch_idx]),
               dat_i >> mtc_pkg::SRC_LSB, sel_i));
         end
         case (adr_i)
            mtc_pkg::START_OFS:
               start_reg <= 5'(mrg(32'(start_reg), dat_i, sel_i));
            mtc_pkg::POL_OFS:
               pol_reg <= 5'(mrg(32'(pol_reg), dat_i, sel_i));
            mtc_pkg::MASK_OFS:
               mask_reg <= 5'(mrg(32'(mask_reg), dat_i, sel_i));
            mtc_pkg::CUT_OFS:
               cut_reg <= 1'(mrg(32'(cut_reg), dat_i, sel_i));
            mtc_pkg::UD_OFS:
               ud_reg <= 5'(mrg(32'(ud_reg), dat_i, sel_i));
            mtc_pkg::TRG_OFS:
               trg_reg <= 5'(mrg(32'(trg_reg), dat_i, sel_i));
            default: start_reg <= start_reg;
         endcase
      end
   end

   // previous start bits, to see start and stop edges
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_q <= 5'h00;
      end else begin
         start_q <= start_reg;
      end
   end

   // ********************************************************
   // pin synchronisers and count sources
   // ********************************************************
   // three stages; the filtered level moves only when stages two
   // and three agree, so a single glitch sample is dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg <= mtc_pkg::SYNC_RST;
         s2_reg <= mtc_pkg::SYNC_RST;
         s3_reg <= mtc_pkg::SYNC_RST;
         flt_reg <= mtc_pkg::SYNC_RST;
         flt_q <= mtc_pkg::SYNC_RST;
      end else begin
         s1_reg <= {shutdown_input_pin_n_i, chan_trigger_input_pin_i};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         flt_reg <= ((s2_reg ~^ s3_reg) & s3_reg) |
            ((s2_reg ^ s3_reg) & flt_reg);
         flt_q <= flt_reg;
      end
   end
   assign pin_rise = flt_reg[4:0] & ~flt_q[4:0];

   // free-running prescaler shared by all channels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_reg <= 5'h00;
      end else begin
         pre_reg <= pre_reg + 5'h01;
      end
   end

   // per-channel count tick and trigger
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         case (src_reg[i])
            mtc_pkg::SRC_DIV1: tick[i] = 1'b1;
            mtc_pkg::SRC_DIV8:
               tick[i] = (pre_reg & mtc_pkg::PRE_DIV8) == 5'h00;
            mtc_pkg::SRC_DIV32:
               tick[i] = (pre_reg & mtc_pkg::PRE_DIV32) == 5'h00;
            default: tick[i] = pin_rise[i];
         endcase
         // external trigger or the start bit itself
         trig[i] = trg_reg[i] ? pin_rise[i]
            : (start_reg[i] & ~start_q[i]);
         cnt_wr[i] = wr && ch_hit && adr_i[mtc_pkg::CH_CNT_BIT] &&
            (ch_idx == 3'(i));
         stop_ev[i] = start_q[i] & ~start_reg[i] &
            ((mode_reg[i] == mtc_pkg::MODE_OS) ||
            ((mode_reg[i] == mtc_pkg::MODE_PWM) &&
            (out_reg[i] != pol_reg[i])));
         mode_ev[i] = wr && ch_hit && !adr_i[mtc_pkg::CH_CNT_BIT] &&
            (ch_idx == 3'(i)) && sel_i[0] && dat_i[1] &&
            !mode_reg[i][1];
      end
   end

   // ********************************************************
   // channel engines
   // ********************************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_reg <= 5'h00;
         act_reg <= 5'h00;
         rtg_reg <= 5'h00;
         pend_reg <= 5'h00;
         rld_reg <= 5'h00;
         kind_reg <= 5'h00;
         uf_ev_reg <= 5'h00;
         for (int i = 0; i < NCH; i++) begin
            cnt_reg[i] <= mtc_pkg::CNT_RST;
            rel_reg[i] <= mtc_pkg::CNT_RST;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            uf_ev_reg[i] <= 1'b0;
            rld_reg[i] <= 1'b0;
            if (cnt_wr[i]) begin
               rel_reg[i] <= 16'(mrg(32'(rel_reg[i]), dat_i, sel_i));
            end
            if (!start_reg[i]) begin
               act_reg[i] <= 1'b0;
               rtg_reg[i] <= 1'b0;
               pend_reg[i] <= 1'b0;
               if (start_q[i] && mode_reg[i] == mtc_pkg::MODE_OS) begin
                  cnt_reg[i] <= rel_reg[i];
               end
               if (mode_reg[i][1]) begin
                  out_reg[i] <= pol_reg[i];
               end
               if (cnt_wr[i]) begin
                  cnt_reg[i] <= 16'(mrg(32'(cnt_reg[i]), dat_i,
                     sel_i));
               end
            end else begin
               case (mode_reg[i])
                  mtc_pkg::MODE_TMR: begin
                     if (tick[i]) begin
                        if (cnt_reg[i] == mtc_pkg::CNT_RST) begin
                           cnt_reg[i] <= rel_reg[i];
                           rld_reg[i] <= 1'b1;
                           kind_reg[i] <= 1'b0;
                           uf_ev_reg[i] <= 1'b1;
                           out_reg[i] <= ~out_reg[i];
                        end else begin
                           cnt_reg[i] <= cnt_reg[i] - 16'h0001;
                        end
                     end
                  end
                  mtc_pkg::MODE_EVT: begin
                     if (pin_rise[i]) begin
                        if (ud_reg[i] &&
                           cnt_reg[i] == mtc_pkg::CNT_MAX) begin
                           cnt_reg[i] <= rel_reg[i];
                           rld_reg[i] <= 1'b1;
                           kind_reg[i] <= 1'b1;
                           uf_ev_reg[i] <= 1'b1;
                        end else if (!ud_reg[i] &&
                           cnt_reg[i] == mtc_pkg::CNT_RST) begin
                           cnt_reg[i] <= rel_reg[i];
                           rld_reg[i] <= 1'b1;
                           kind_reg[i] <= 1'b0;
                           uf_ev_reg[i] <= 1'b1;
                        end else if (ud_reg[i]) begin
                           cnt_reg[i] <= cnt_reg[i] + 16'h0001;
                        end else begin
                           cnt_reg[i] <= cnt_reg[i] - 16'h0001;
                        end
                     end
                  end
                  mtc_pkg::MODE_OS: begin
                     if (trig[i] && !act_reg[i]) begin
                        act_reg[i] <= 1'b1;
                        out_reg[i] <= ~pol_reg[i];
                        cnt_reg[i] <= rel_reg[i];
                     end else if (trig[i]) begin
                        rtg_reg[i] <= 1'b1;
                     end
                     // output goes active on a trigger and returns to its stop level on the tick that finds the count at zero, or when the channel is stopped
                     if (act_reg[i] && tick[i]) begin
                        if (pend_reg[i]) begin
                           cnt_reg[i] <= rel_reg[i];
                           pend_reg[i] <= 1'b0;
                        end else if (cnt_reg[i] == mtc_pkg::CNT_RST) begin
                           act_reg[i] <= 1'b0;
                           out_reg[i] <= pol_reg[i];
                           cnt_reg[i] <= rel_reg[i];
                           uf_ev_reg[i] <= 1'b1;
                        end else begin
                           cnt_reg[i] <= cnt_reg[i] - 16'h0001;
                           if (rtg_reg[i]) begin
                              pend_reg[i] <= 1'b1;
                              rtg_reg[i] <= 1'b0;
                           end
                        end
                     end
                  end
                  default: begin
                     // pwm: active phase of reload+1 ticks, idle phase
                     // of the complement+1, so the period is 2^16+1 ticks
                     if (trig[i] && !act_reg[i]) begin
                        act_reg[i] <= 1'b1;
                        out_reg[i] <= ~pol_reg[i];
                        cnt_reg[i] <= rel_reg[i];
                     end else if (act_reg[i] && tick[i]) begin
                        if (cnt_reg[i] == mtc_pkg::CNT_RST) begin
                           out_reg[i] <= ~out_reg[i];
                           cnt_reg[i] <= (out_reg[i] != pol_reg[i]) ?
                              ~rel_reg[i] : rel_reg[i];
                           uf_ev_reg[i] <= out_reg[i] != pol_reg[i];
                        end else begin
                           cnt_reg[i] <= cnt_reg[i] - 16'h0001;
                        end
                     end
                  end
               endcase
            end
         end
      end
   end

   // ********************************************************
   // interrupt requests
   // ********************************************************
   // a read of the status clears it, but an event in that same
   // cycle survives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_reg <= 5'h00;
      end else begin
         stat_reg <= ((rd && adr_i == mtc_pkg::STAT_OFS) ? 5'h00
            : stat_reg) | uf_ev_reg | stop_ev | mode_ev;
      end
   end
   assign irq_o = |(stat_reg & mask_reg);

   // ********************************************************
   // output pins
   // ********************************************************
   assign chan_output_pin_o = out_reg;
   assign chan_output_oe_o = ~({5{cut_reg & ~flt_reg[mtc_pkg::SD_BIT]}}
      & mtc_pkg::CUT_CH_MASK);
endmodule : mtc_timer

// *** tb/mtc_timer_properties.sv ***
// mtc_timer_properties: concurrent checks on the ports of mtc_timer.
// assumes the mtc_pkg map and a master that holds requests until ack.
`timescale 1ns/1ps
module mtc_chk (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic [4:0] chan_trigger_input_pin_i,
   input wire logic shutdown_input_pin_n_i,
   input wire logic [4:0] chan_output_pin_o,
   input wire logic [4:0] chan_output_oe_o,
   input wire logic irq_o
);
   // ***********************************************************
   // shadow of software-written fields
   // ***********************************************************
   logic wr;
   logic [4:0] start_reg;
   logic [4:0] pol_reg;
   logic [4:0] mask_reg;
   logic cut_reg;
   logic [1:0] mode_reg;
   // only lane 0 is followed: every field watched here sits in it
   assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
   // writes land at the edge that takes the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_reg <= 5'h00;
         pol_reg <= 5'h00;
         mask_reg <= 5'h00;
         cut_reg <= 1'b0;
         mode_reg <= 2'h0;
      end else if (wr) begin
         if (adr_i == mtc_pkg::START_OFS) start_reg <= dat_i[4:0];
         if (adr_i == mtc_pkg::POL_OFS) pol_reg <= dat_i[4:0];
         if (adr_i == mtc_pkg::MASK_OFS) mask_reg <= dat_i[4:0];
         if (adr_i == mtc_pkg::CUT_OFS) cut_reg <= dat_i[0];
         if (adr_i == mtc_pkg::CH_BASE) mode_reg <= dat_i[1:0];
      end
   end
   // ***********************************************************
   // properties
   // ***********************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence req_s;
      cyc_i && stb_i && !ack_o;
   endsequence
   // channel 0 leaves a one-shot or pwm run
   sequence stop_s;
      $fell(start_reg[0]) && mode_reg[1];
   endsequence
   sequence mode_up_s;
      wr && adr_i == mtc_pkg::CH_BASE && dat_i[1] && !mode_reg[1];
   endsequence
   ack_pulse_a: assert property (req_s |=> ack_o ##1 !ack_o)
      else $error("bus answer is not one ack pulse");
   reset_quiet_a: assert property (
      $fell(rst_i) |-> chan_output_pin_o == 5'h00 && !irq_o
         && chan_output_oe_o == 5'h1F)
      else $error("outputs not idle after reset");
   stopped_hold_a: assert property (
      (start_reg == 5'h00 && $stable(pol_reg) && $stable(mode_reg))[*4]
         |-> $stable(chan_output_pin_o))
      else $error("stopped channel moved its pin");
   stop_level_a: assert property (
      stop_s |-> ##[1:2] chan_output_pin_o[0] == pol_reg[0])
      else $error("stop did not leave the pin at its stop level");
   stop_irq_a: assert property (
      stop_s and (mode_reg == mtc_pkg::MODE_OS && mask_reg[0])
         |-> ##[0:2] irq_o)
      else $error("one-shot stop raised no request");
   mode_irq_a: assert property (
      mode_up_s and mask_reg[0] |-> ##[1:2] irq_o)
      else $error("mode change raised no request");
   mask_quiet_a: assert property (mask_reg == 5'h00 |-> !irq_o)
      else $error("irq high with every source masked");
   cutoff_float_a: assert property (
      (cut_reg && !shutdown_input_pin_n_i)[*6]
         |-> (chan_output_oe_o & mtc_pkg::CUT_CH_MASK) == 5'h00)
      else $error("cutoff did not float channels 1 2 4");
   keep_drive_a: assert property (
      chan_output_oe_o[0] && chan_output_oe_o[3])
      else $error("channel 0 or 3 floated");
   cutoff_off_a: assert property (
      !cut_reg |-> chan_output_oe_o == 5'h1F)
      else $error("pin floated without cutoff enabled");
endmodule : mtc_chk

bind mtc_timer mtc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
   .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
   .chan_trigger_input_pin_i(chan_trigger_input_pin_i),
   .shutdown_input_pin_n_i(shutdown_input_pin_n_i),
   .chan_output_pin_o(chan_output_pin_o),
   .chan_output_oe_o(chan_output_oe_o), .irq_o(irq_o));

// *** tb/mtc_timer_tb.sv ***
// mtc_timer_tb: self-checking bench for the five-channel timer.
// assumes mtc_pkg and a checker bound in mtc_timer_properties.sv.
`timescale 1ns/1ps
module mtc_timer_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic we_i = 1'b0;
   logic [3:0] sel_i = 4'hF;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic [4:0] trig_i = 5'h00;
   logic sd_n_i = 1'b1;
   logic [31:0] dat_o;
   logic ack_o;
   logic [4:0] pin_o;
   logic [4:0] oe_o;
   logic irq_o;
   int failures = 0;
   int total_checks = 0;
   int seed = 32'hF435;
   int model[64]; // expected readback of settable registers
   int n;
   logic [31:0] rd;
   logic [7:0] wa[10] = '{8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
      8'h24, 8'h3C, 8'h44, 8'h48};
   always #25 clk_i = ~clk_i;
   mtc_timer uut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
      .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .chan_trigger_input_pin_i(trig_i), .shutdown_input_pin_n_i(sd_n_i),
      .chan_output_pin_o(pin_o), .chan_output_oe_o(oe_o), .irq_o(irq_o));
   // ***********************************************************
   // checking and bus tasks
   // ***********************************************************
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         failures++;
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test
   // one classic cycle; the answer delay is never assumed
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && k < 20) begin
         k++;
         @(posedge clk_i);
      end
      if (k == 20) failures++;
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask : wb
   // unmapped places read zero, so their model width is nothing
   function automatic int wmask(input logic [7:0] a);
      if (a == 8'h1C || a == 8'h08 || a >= 8'h48) return 0;
      if (a >= mtc_pkg::CH_BASE) return a[2] ? 32'hFFFF : 32'hF;
      return a == mtc_pkg::CUT_OFS ? 1 : 32'h1F;
   endfunction : wmask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      model[a[7:2]] = d & wmask(a);
      wb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a);
      wb(1'b0, a, 32'h0);
      check("readback", rd, model[a[7:2]]);
   endtask : rdc
   task automatic stat(input logic [31:0] exp);
      wb(1'b0, mtc_pkg::STAT_OFS, 32'h0);
      check("status", rd, exp);
   endtask : stat
   task automatic wait_pin(input logic lvl);
      n = 0;
      while (pin_o[0] !== lvl && n < 60) begin
         n++;
         @(posedge clk_i);
      end
      check("pin reached", 32'(n < 60), 32'h1);
   endtask : wait_pin
   // pwm stop once while idle, once while active
   task automatic pwm_stop(input logic p);
      wr(mtc_pkg::CH_BASE, mtc_pkg::MODE_TMR);
      wr(mtc_pkg::POL_OFS, 32'(p));
      wb(1'b0, mtc_pkg::STAT_OFS, 32'h0);
      wr(mtc_pkg::CH_BASE, mtc_pkg::MODE_PWM);
      stat(32'h1);
      wr(mtc_pkg::CH_BASE + 8'h04, 32'h7);
      wr(mtc_pkg::START_OFS, 32'h1);
      wait_pin(~p);
      wait_pin(p);
      // the end of the active phase has raised a request of its own
      wb(1'b0, mtc_pkg::STAT_OFS, 32'h0);
      wr(mtc_pkg::START_OFS, 32'h0);
      @(negedge clk_i);
      check("idle stop pin", 32'(pin_o[0]), 32'(p));
      stat(32'h0);
      wr(mtc_pkg::START_OFS, 32'h1);
      wait_pin(~p);
      wr(mtc_pkg::START_OFS, 32'h0);
      @(negedge clk_i);
      check("active stop pin", 32'(pin_o[0]), 32'(p));
      stat(32'h1);
   endtask : pwm_stop
   // ***********************************************************
   // watchdog and main sequence
   // ***********************************************************
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 8'h4C; a += 4) rdc(8'(a));
      $display("test reset values done");
      for (int i = 0; i < 12; i++) begin
         n = $unsigned($random(seed)) % 10;
         wr(wa[n], $random(seed));
         rdc(wa[n]);
      end
      wr(mtc_pkg::CUT_OFS, 32'h0);
      wr(mtc_pkg::TRG_OFS, 32'h0);
      $display("test random registers done");
      // timer reads, reload visible as all ones
      wr(mtc_pkg::CH_BASE + 8'h04, 32'h3);
      wr(mtc_pkg::START_OFS, 32'h1);
      n = 0;
      repeat (16) begin
         wb(1'b0, mtc_pkg::CH_BASE + 8'h04, 32'h0);
         check("count range", 32'(rd[15:0] <= 3 || rd[15:0] == 16'hFFFF),
            32'h1);
         if (rd[15:0] === mtc_pkg::RD_UDF) n++;
      end
      check("reload read seen", 32'(n > 0), 32'h1);
      wr(mtc_pkg::START_OFS, 32'h0);
      $display("test timer read done");
      // one-shot entry flag, stop reload, level and request
      wr(mtc_pkg::MASK_OFS, 32'h1);
      wb(1'b0, mtc_pkg::STAT_OFS, 32'h0);
      wr(mtc_pkg::CH_BASE, mtc_pkg::MODE_OS);
      @(negedge clk_i);
      check("entry irq", 32'(irq_o), 32'h1);
      stat(32'h1);
      stat(32'h0);
      wr(mtc_pkg::POL_OFS, 32'h1);
      wr(mtc_pkg::CH_BASE + 8'h04, 32'h10);
      wr(mtc_pkg::START_OFS, 32'h1);
      wr(mtc_pkg::START_OFS, 32'h0);
      @(negedge clk_i);
      check("stop level", 32'(pin_o[0]), 32'h1);
      check("stop irq", 32'(irq_o), 32'h1);
      rdc(mtc_pkg::CH_BASE + 8'h04);
      stat(32'h1);
      // external trigger: five sync edges plus one and a half ticks
      wr(mtc_pkg::TRG_OFS, 32'h1);
      wr(mtc_pkg::START_OFS, 32'h1);
      @(posedge clk_i);
      trig_i <= 5'h01;
      @(posedge clk_i);
      wait_pin(1'b0);
      check("trigger delay", 32'(n <= 7), 32'h1);
      trig_i <= 5'h00;
      // second trigger mid-count: one more count, then a full reload
      repeat (2) @(posedge clk_i);
      trig_i <= 5'h01;
      wait_pin(1'b1);
      check("retrigger length", n, 32'h19);
      trig_i <= 5'h00;
      wr(mtc_pkg::START_OFS, 32'h0);
      wr(mtc_pkg::TRG_OFS, 32'h0);
      $display("test one-shot done");
      // event counter: reads at the reload give 0000h or FFFFh
      wr(mtc_pkg::CH_BASE, mtc_pkg::MODE_EVT);
      for (int u = 1; u >= 0; u--) begin
         wr(mtc_pkg::UD_OFS, 32'(u));
         wr(mtc_pkg::CH_BASE + 8'h04, u ? 32'hFFFF : 32'h0);
         wr(mtc_pkg::START_OFS, 32'h1);
         trig_i <= 5'h01;
         repeat (4) @(posedge clk_i);
         wb(1'b0, mtc_pkg::CH_BASE + 8'h04, 32'h0);
         check("reload read", rd, u ? 32'h0 : 32'hFFFF);
         trig_i <= 5'h00;
         wr(mtc_pkg::START_OFS, 32'h0);
      end
      $display("test event counter done");
      pwm_stop(1'b0);
      pwm_stop(1'b1);
      $display("test pwm stop done");
      // forced cutoff floats channels 1, 2 and 4 only
      wr(mtc_pkg::CUT_OFS, 32'h1);
      sd_n_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      check("cutoff oe", 32'(oe_o), 32'h09);
      sd_n_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      check("released oe", 32'(oe_o), 32'h1F);
      $display("test cutoff done");
      stop_test();
   end
endmodule : mtc_timer_tb
